// >>> asmr_regs.sv
// module: apb slave holding the identity, status and mode registers of the converter
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
// Behaviour
// R1 - identity reads channel count two in bits 11:8, read only
// R2 - host ignores identity low byte, it is revision dependent
// R3 - status register at index one, 0500h after reset
// R4 - status bit 15 shows serial lock, zero after reset; the code passes core_in.lock straight through, unaffected by reset
// R5 - status bit 14 set whenever conversions resynchronize
// R6 - status bit 13 set when register map checksum changed
// R7 - status bit 12 set on incoming frame checksum error
// R8 - status bit 11 reports checksum type, zero CCITT, one ANSI
// R9 - status bit 10 set after reset, held until cleared
// R10 - status bits 9:8 report word length, default 01
// R11 - status bit 1 flags new channel one data
// R12 - status bit 0 flags new channel zero data
// R13 - mode register at index two, read write, 0510h after reset
// R14 - writing zero to mode reset bit clears the status reset flag
// R15 - mode bits 13 and 12 enable map and input checksums, off at reset
// R16 - ready source: lagging, OR, or leading enabled channel
// R17 - idle pin high or floating; active low level or fixed pulse
// R18 - status checksum type, reset and length mirror mode fields
// R19 - status bits 7:2 read zero; writes to identity and status ignored
module asmr_regs (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire asmr_pkg::asmr_core_s core_in,
	output asmr_pkg::asmr_cfg_s cfg_out,
	output logic data_ready_pin_out,
	output logic data_ready_pin_oe_out,
	output logic irq_out
);
	import asmr_pkg::*;

	logic [15:0] mode_reg;
	logic resync_event_flag_reg, map_change_reg, crc_err_reg;
	logic [1:0] new_sample_reg;
	logic [15:0] last_crc_reg;
	logic crc_seen_reg;
	logic [ASMR_IRQ_W-1:0] irq_stat_reg, irq_mask_reg;
	logic [15:0] status_view, ident_view;
	logic wr_access, rd_access, addr_ok, st_rd;
	logic map_crc_change;
	logic [ASMR_IRQ_W-1:0] irq_events;
	asmr_rdy_e rdy_state_reg;
	logic [2:0] pulse_cnt_reg;
	logic ready_source, ready_source_prev_reg;
	asmr_src_e ready_source_sel;

	// ****************************************************************
	// bus decode
	// ****************************************************************
	// zero-wait slave: the access phase completes at once
	assign pready_out = 1'b1;
	assign wr_access = psel_in & penable_in & pwrite_in;
	assign rd_access = psel_in & penable_in & ~pwrite_in;
	assign addr_ok = (paddr_in == ASMR_ADDR_IDENTITY) | (paddr_in == ASMR_ADDR_STATUS) |
		(paddr_in == ASMR_ADDR_MODE) | (paddr_in == ASMR_ADDR_IRQ_STAT) |
		(paddr_in == ASMR_ADDR_IRQ_MASK);
	assign pslverr_out = psel_in & penable_in & ~addr_ok;
	assign st_rd = rd_access & (paddr_in == ASMR_ADDR_STATUS);

	// identity view: fixed upper nibbles and a revision byte
	assign ident_view = {ASMR_ID_UPPER, ASMR_CHANNEL_QUANTITY, ASMR_REVISION_DEFAULT}; // R1

	// status view assembled from live flags and mirrored mode fields
	assign status_view = {core_in.lock, resync_event_flag_reg, map_change_reg, crc_err_reg, // R4
		mode_reg[ASMR_MD_CRCTYPE], mode_reg[ASMR_MD_RESET], mode_reg[9:8], // R18 R9
		6'h00, new_sample_reg}; // R19

	// ****************************************************************
	// mode register
	// ****************************************************************
	// low byte lane and high byte lane written separately
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			mode_reg <= ASMR_MODE_RST; // R13 R15
		end else if (wr_access && paddr_in == ASMR_ADDR_MODE) begin
			if (pstrb_in[0]) begin
				mode_reg[7:0] <= pwdata_in[7:0];
			end
			if (pstrb_in[1]) begin
				mode_reg[15:8] <= pwdata_in[15:8]; // R14
			end
		end
	end

	assign cfg_out.map_crc_en = mode_reg[ASMR_MD_MAPCRC_EN]; // R15
	assign cfg_out.rx_crc_en = mode_reg[ASMR_MD_RXCRC_EN]; // R15
	assign cfg_out.crc_type = mode_reg[ASMR_MD_CRCTYPE]; // R8
	assign cfg_out.word_size_sel = mode_reg[9:8]; // R10
	assign cfg_out.timeout_en = mode_reg[ASMR_MD_TIMEOUT];

	// ****************************************************************
	// status event flags
	// ****************************************************************
	// remember the last checksum so a change is detectable; first value only primes it
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			last_crc_reg <= 16'h0000;
			crc_seen_reg <= 1'b0;
		end else if (core_in.map_crc_value_valid && mode_reg[ASMR_MD_MAPCRC_EN]) begin
			last_crc_reg <= core_in.map_crc_value;
			crc_seen_reg <= 1'b1;
		end
	end
	assign map_crc_change = core_in.map_crc_value_valid & mode_reg[ASMR_MD_MAPCRC_EN] &
		crc_seen_reg & (core_in.map_crc_value != last_crc_reg);

	// flags clear on a status read; a new event in that cycle wins
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			resync_event_flag_reg <= 1'b0;
			map_change_reg <= 1'b0;
			crc_err_reg <= 1'b0;
		end else begin
			resync_event_flag_reg <= core_in.resync | (resync_event_flag_reg & ~st_rd); // R5
			map_change_reg <= map_crc_change | (map_change_reg & ~st_rd); // R6
			crc_err_reg <= (core_in.rx_crc_error & mode_reg[ASMR_MD_RXCRC_EN]) |
				(crc_err_reg & ~st_rd); // R7
		end
	end

	// per-channel new data, cleared when the core reports the sample taken
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_chan
			always_ff @(posedge clk_in) begin
				if (!reset_n_in) begin
					new_sample_reg[ch] <= 1'b0;
				end else begin
					new_sample_reg[ch] <= core_in.new_sample[ch] |
						(new_sample_reg[ch] & ~core_in.sample_taken[ch]); // R11 R12
				end
			end
		end
	endgenerate

	// ****************************************************************
	// interrupt status and mask
	// ****************************************************************
	assign irq_events = {|core_in.new_sample, core_in.rx_crc_error & mode_reg[ASMR_MD_RXCRC_EN],
		map_crc_change, core_in.resync};
	// write one to clear; a coincident event keeps its bit
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			irq_stat_reg <= '0;
		end else if (wr_access && paddr_in == ASMR_ADDR_IRQ_STAT && pstrb_in[0]) begin
			irq_stat_reg <= irq_events | (irq_stat_reg & ~pwdata_in[ASMR_IRQ_W-1:0]);
		end else begin
			irq_stat_reg <= irq_events | irq_stat_reg;
		end
	end
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			irq_mask_reg <= '0;
		end else if (wr_access && paddr_in == ASMR_ADDR_IRQ_MASK && pstrb_in[0]) begin
			irq_mask_reg <= pwdata_in[ASMR_IRQ_W-1:0];
		end
	end
	assign irq_out = |(irq_stat_reg & irq_mask_reg);

	// ****************************************************************
	// read data
	// ****************************************************************
	// identity and status have no write path, so writes there are dropped
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			prdata_out <= 32'h0000_0000;
		end else if (psel_in && !penable_in && !pwrite_in) begin
			case (paddr_in)
				ASMR_ADDR_IDENTITY: prdata_out <= {16'h0000, ident_view}; // R1
				ASMR_ADDR_STATUS: prdata_out <= {16'h0000, status_view}; // R3 R19
				ASMR_ADDR_MODE: prdata_out <= {16'h0000, mode_reg};
				ASMR_ADDR_IRQ_STAT: prdata_out <= {28'h000_0000, irq_stat_reg};
				ASMR_ADDR_IRQ_MASK: prdata_out <= {28'h000_0000, irq_mask_reg};
				default: prdata_out <= 32'h0000_0000;
			endcase
		end
	end

	// ****************************************************************
	// data ready pin
	// ****************************************************************
	assign ready_source_sel = asmr_src_e'(mode_reg[3:2]);
	// lagging needs every enabled channel, leading any; OR mode follows any too
	always_comb begin
		ready_source = 1'b0;
		case (ready_source_sel)
			ASMR_SRC_LAG: ready_source = (core_in.chan_enable != 2'b00) &
				((new_sample_reg & core_in.chan_enable) == core_in.chan_enable); // R16
			ASMR_SRC_OR: ready_source = |(new_sample_reg & core_in.chan_enable); // R16
			default: ready_source = |(new_sample_reg & core_in.chan_enable); // R16
		endcase
	end

	// leading and OR modes both react to first arrival only; neither re-arms until the source drops
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			ready_source_prev_reg <= 1'b0;
			rdy_state_reg <= ASMR_RDY_IDLE;
			pulse_cnt_reg <= 3'h0;
		end else begin
			ready_source_prev_reg <= ready_source;
			case (rdy_state_reg)
				ASMR_RDY_IDLE: begin
					if (ready_source && !ready_source_prev_reg) begin
						rdy_state_reg <= mode_reg[ASMR_MD_PULSE] ? ASMR_RDY_PULSE : ASMR_RDY_HELD;
						pulse_cnt_reg <= 3'(ASMR_PULSE_CYC - 1);
					end
				end
				ASMR_RDY_PULSE: begin
					if (pulse_cnt_reg == 3'h0) begin
						rdy_state_reg <= ASMR_RDY_HELD;
					end else begin
						pulse_cnt_reg <= pulse_cnt_reg - 3'h1;
					end
				end
				ASMR_RDY_HELD: begin
					if (!ready_source) begin
						rdy_state_reg <= ASMR_RDY_IDLE;
					end
				end
				default: rdy_state_reg <= ASMR_RDY_IDLE;
			endcase
		end
	end

	// pin low while asserted; otherwise high or released
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			data_ready_pin_out <= 1'b1;
			data_ready_pin_oe_out <= 1'b1;
		end else begin
			if (rdy_state_reg == ASMR_RDY_PULSE ||
				(rdy_state_reg == ASMR_RDY_HELD && !mode_reg[ASMR_MD_PULSE])) begin
				data_ready_pin_out <= 1'b0; // R17
				data_ready_pin_oe_out <= 1'b1;
			end else begin
				data_ready_pin_out <= 1'b1;
				data_ready_pin_oe_out <= ~mode_reg[ASMR_MD_FLOAT]; // R17
			end
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	AST_STATUS_RESET: assert property (@(posedge clk_in) !reset_n_in |=> // R3
		status_view == (ASMR_STATUS_RST | {core_in.lock, 15'h0000}))
		else $error("status not at reset value");
	AST_MODE_RESET: assert property (@(posedge clk_in) !reset_n_in |=> // R13
		mode_reg == ASMR_MODE_RST) else $error("mode not at reset value");
	AST_RESET_ACK: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R14
		(wr_access && paddr_in == ASMR_ADDR_MODE && pstrb_in[1] && !pwdata_in[10])
		|=> !status_view[ASMR_ST_RESET]) else $error("reset flag not cleared");
	AST_RESYNC_SET: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R5
		core_in.resync |=> status_view[ASMR_ST_RESYNC]) else $error("resync lost");
	AST_CRCERR_SET: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R7
		(core_in.rx_crc_error && mode_reg[ASMR_MD_RXCRC_EN]) |=> status_view[ASMR_ST_CRCERR])
		else $error("crc error lost");
	AST_MIRROR: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R18
		status_view[11:8] == mode_reg[11:8]) else $error("status mirror mismatch");
	AST_RESERVED: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R19
		status_view[7:2] == 6'h00) else $error("reserved status bits set");
	AST_CHAN_SET: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R11
		core_in.new_sample[1] |=> status_view[ASMR_ST_CH1]) else $error("ch1 flag lost");
	AST_PULSE_LEN: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R17
		$rose(rdy_state_reg == ASMR_RDY_PULSE) |=> (!data_ready_pin_out) [*4] ##1
		data_ready_pin_out) else $error("ready pulse width wrong");
	AST_FLOAT_IDLE: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R17
		(rdy_state_reg == ASMR_RDY_IDLE && mode_reg[ASMR_MD_FLOAT]) |=> !data_ready_pin_oe_out)
		else $error("idle pin not released");
endmodule // asmr_regs

// >>> asmr_pkg.sv
// package: register map, field positions and reset values of the status and mode bank
package asmr_pkg;
	// ****************************************************************
	// register indices; byte address is four times the index
	// ****************************************************************
	localparam logic [1:0] ASMR_IDX_IDENTITY = 2'h0;
	localparam logic [1:0] ASMR_IDX_STATUS = 2'h1;
	localparam logic [1:0] ASMR_IDX_MODE = 2'h2;
	localparam logic [1:0] ASMR_IDX_IRQ_STAT = 2'h3;
	localparam logic [7:0] ASMR_IDX_IRQ_MASK = 8'h04;
	localparam logic [7:0] ASMR_ADDR_IDENTITY = 8'h00;
	localparam logic [7:0] ASMR_ADDR_STATUS = 8'h04;
	localparam logic [7:0] ASMR_ADDR_MODE = 8'h08;
	localparam logic [7:0] ASMR_ADDR_IRQ_STAT = 8'h0C;
	localparam logic [7:0] ASMR_ADDR_IRQ_MASK = 8'h10;
	// ****************************************************************
	// reset values and fixed fields
	// ****************************************************************
	localparam logic [15:0] ASMR_STATUS_RST = 16'h0500;
	localparam logic [15:0] ASMR_MODE_RST = 16'h0510;
	localparam logic [3:0] ASMR_ID_UPPER = 4'h2;
	localparam logic [3:0] ASMR_CHANNEL_QUANTITY = 4'h2;
	localparam logic [7:0] ASMR_REVISION_DEFAULT = 8'h5A; // arbitrary value
	// ****************************************************************
	// status bit positions
	// ****************************************************************
	localparam int ASMR_ST_LOCK = 15;
	localparam int ASMR_ST_RESYNC = 14;
	localparam int ASMR_ST_MAPCRC = 13;
	localparam int ASMR_ST_CRCERR = 12;
	localparam int ASMR_ST_CRCTYPE = 11;
	localparam int ASMR_ST_RESET = 10;
	localparam int ASMR_ST_CH1 = 1;
	localparam int ASMR_ST_CH0 = 0;
	// ****************************************************************
	// mode bit positions
	// ****************************************************************
	localparam int ASMR_MD_MAPCRC_EN = 13;
	localparam int ASMR_MD_RXCRC_EN = 12;
	localparam int ASMR_MD_CRCTYPE = 11;
	localparam int ASMR_MD_RESET = 10;
	localparam int ASMR_MD_TIMEOUT = 4;
	localparam int ASMR_MD_FLOAT = 1;
	localparam int ASMR_MD_PULSE = 0;
	// interrupt event bits: 0 resync, 1 map crc change, 2 input crc error, 3 new data
	localparam int ASMR_IRQ_W = 4;
	// ready pulse width in ns at 10 MHz clock
	localparam int ASMR_CLK_NS = 100;
	localparam int ASMR_PULSE_NS = 400;
	localparam int ASMR_PULSE_CYC = (ASMR_PULSE_NS + ASMR_CLK_NS - 1) / ASMR_CLK_NS;
	// ready source select codes
	typedef enum logic [1:0] {
		ASMR_SRC_LAG = 2'b00,
		ASMR_SRC_OR = 2'b01,
		ASMR_SRC_LEAD = 2'b10,
		ASMR_SRC_LEAD2 = 2'b11
	} asmr_src_e;
	// ready pin state machine, gray along idle to pulse to held
	typedef enum logic [1:0] {
		ASMR_RDY_IDLE = 2'b00,
		ASMR_RDY_PULSE = 2'b01,
		ASMR_RDY_HELD = 2'b11
	} asmr_rdy_e;
	// event inputs from the converter core
	typedef struct packed {
		logic lock;
		logic resync;
		logic map_crc_value_valid;
		logic [15:0] map_crc_value;
		logic rx_crc_error;
		logic [1:0] chan_enable;
		logic [1:0] new_sample;
		logic [1:0] sample_taken;
	} asmr_core_s;
	// configuration outputs toward the core
	typedef struct packed {
		logic map_crc_en;
		logic rx_crc_en;
		logic crc_type;
		logic [1:0] word_size_sel;
		logic timeout_en;
	} asmr_cfg_s;
endpackage

// >>> asmr_core_model.sv
// partner: converter core model that turns bench requests into event pulses
`timescale 1ns/1ps
module asmr_core_model
	import asmr_pkg::*;
(
	input wire logic clk_in,
	input wire logic lock_in,
	input wire logic [1:0] chan_en_in,
	input wire logic [15:0] crc_val_in,
	input wire logic [6:0] ev_in,
	output asmr_pkg::asmr_core_s core_out
);
	import asmr_pkg::*;
	logic [6:0] ev_reg = '0;
	// requests are registered, so each event launches off an edge one cycle later and lasts as long as its request, like the real core
	always_ff @(posedge clk_in) begin
		ev_reg <= ev_in;
	end
	// levels and the checksum value pass straight through; its valid pulse is registered
	assign core_out = '{lock: lock_in, resync: ev_reg[0], map_crc_value_valid: ev_reg[1],
		map_crc_value: crc_val_in, rx_crc_error: ev_reg[2], chan_enable: chan_en_in,
		new_sample: ev_reg[4:3], sample_taken: ev_reg[6:5]};
endmodule // asmr_core_model

// >>> asmr_regs_tb_top.sv
// testbench: apb register accesses and core events against the status and mode bank
`timescale 1ns/1ps
module asmr_regs_tb_top;
	import asmr_pkg::*;
	logic clk_in = 0, reset_n_in = 0, psel = 0, penable = 0, pwrite = 0, lock = 0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [3:0] pstrb = '0;
	logic pready, pslverr, err, pin, oe, irq;
	logic [1:0] chan_en = '0;
	logic [15:0] crc_val = '0;
	logic [6:0] ev = '0;
	asmr_core_s core;
	asmr_cfg_s cfg;
	int fails = 0, compares = 0;
	asmr_core_model i_asmr_core_model (.clk_in(clk_in), .lock_in(lock), .chan_en_in(chan_en),
		.crc_val_in(crc_val), .ev_in(ev), .core_out(core));
	asmr_regs i_asmr_regs (.clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.core_in(core), .cfg_out(cfg), .data_ready_pin_out(pin),
		.data_ready_pin_oe_out(oe), .irq_out(irq));
	// ****************************************************************
	// shared tasks
	// ****************************************************************
	initial begin
		forever #50 clk_in = ~clk_in;
	end
	task automatic complete_run();
		$display("fails=%0d compares=%0d", fails, compares);
		if (fails == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		@(posedge clk_in);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= w ? s : 4'h0;
		@(posedge clk_in);
		penable <= 1;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			complete_run();
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		apb(1, a, {16'h0000, d}, 4'hf);
	endtask
	// status read against the expected word
	task automatic st(input logic [15:0] e);
		apb(0, ASMR_ADDR_STATUS, '0, '0);
		chk(rd, {16'h0000, e});
	endtask
	task automatic pulse(input logic [6:0] e);
		@(posedge clk_in);
		ev <= e;
		@(posedge clk_in);
		ev <= '0;
		repeat (2) @(posedge clk_in);
	endtask
	// pin sampled mid-cycle, bounded wait
	task automatic wait_pin(input logic v);
		int n;
		for (n = 0; n < 12 && pin !== v; n++) begin
			@(negedge clk_in);
		end
		chk(pin, v);
		if (n >= 12) begin
			complete_run();
		end
	endtask
	// ****************************************************************
	// scenarios
	// ****************************************************************
	initial begin
		repeat (16) @(posedge clk_in);
		reset_n_in <= 1;
		apb(0, ASMR_ADDR_IDENTITY, '0, '0);
		chk(rd[15:8], 8'h22);
		chk(rd[31:16], 16'h0000);
		st(16'h0500);
		apb(0, ASMR_ADDR_MODE, '0, '0);
		chk(rd, 32'h0000_0510);
		chk({cfg.map_crc_en, cfg.rx_crc_en}, 2'b00);
		chk(cfg.timeout_en, 1'b1);
		chk({pin, oe, irq}, 3'b110);
		wr(ASMR_ADDR_IDENTITY, 16'hffff);
		wr(ASMR_ADDR_STATUS, 16'hffff);
		apb(0, ASMR_ADDR_IDENTITY, '0, '0);
		chk(rd[15:8], 8'h22);
		st(16'h0500);
		apb(1, 8'h14, 32'h0000_ffff, 4'hf);
		chk(err, 1'b1);
		apb(0, 8'h14, '0, '0);
		chk({err, rd}, {1'b1, 32'h0});
		// every word size and both checksum types mirrored into status
		for (int i = 0; i < 4; i++) begin
			wr(ASMR_ADDR_MODE, 16'h0410 | 16'(i << 8) | 16'(i[0] << 11));
			st(16'h0400 | 16'(i << 8) | 16'(i[0] << 11));
			chk({cfg.word_size_sel, cfg.crc_type}, {2'(i), i[0]});
		end
		wr(ASMR_ADDR_MODE, 16'h3110);
		st(16'h0100);
		apb(1, ASMR_ADDR_MODE, 32'h0, 4'h1);
		apb(0, ASMR_ADDR_MODE, '0, '0);
		chk(rd, 32'h0000_3100);
		wr(ASMR_ADDR_MODE, 16'h3110);
		// the write lands at the access edge; look one edge later
		@(posedge clk_in);
		chk({cfg.map_crc_en, cfg.rx_crc_en}, 2'b11);
		lock <= 1;
		st(16'h8100);
		// events set sticky bits; a status read clears them, irq follows mask
		wr(ASMR_ADDR_IRQ_MASK, 16'h000f);
		pulse(7'h01);
		chk(irq, 1'b1);
		st(16'hc100);
		st(16'h8100);
		wr(ASMR_ADDR_IRQ_STAT, 16'h000f);
		@(posedge clk_in);
		chk(irq, 1'b0);
		crc_val <= 16'h1234;
		pulse(7'h02);
		crc_val <= 16'h4321;
		pulse(7'h02);
		st(16'ha100);
		pulse(7'h04);
		st(16'h9100);
		wr(ASMR_ADDR_IRQ_MASK, 16'h0000);
		wr(ASMR_ADDR_IRQ_STAT, 16'h000f);
		pulse(7'h04);
		chk(irq, 1'b0);
		// ready pin: OR source, then lagging, then pulse with floating idle
		chan_en <= 2'b11;
		wr(ASMR_ADDR_MODE, 16'h3114);
		pulse(7'h08);
		wait_pin(0);
		// input crc error from the masked pulse is still sticky until this read
		st(16'h9101);
		pulse(7'h20);
		wait_pin(1);
		pulse(7'h10);
		st(16'h8102);
		pulse(7'h40);
		wr(ASMR_ADDR_MODE, 16'h3110);
		pulse(7'h08);
		repeat (4) @(negedge clk_in);
		chk(pin, 1'b1);
		pulse(7'h10);
		wait_pin(0);
		pulse(7'h60);
		wr(ASMR_ADDR_MODE, 16'h311b);
		// mode lands at the access edge, the registered enable one edge later
		repeat (2) @(posedge clk_in);
		chk(oe, 1'b0);
		pulse(7'h08);
		wait_pin(0);
		repeat (3) begin
			@(negedge clk_in);
			chk({pin, oe}, 2'b01);
		end
		@(negedge clk_in);
		chk(oe, 1'b0);
		complete_run();
	end
endmodule // asmr_regs_tb_top
